// ---- pclc_pkg.sv ----
// Purpose: Constants shared by the link control register bank.
// Assumes: One 16-bit register at a fixed configuration offset.
// Notes: Every offset, field position, reset value and latency code lives here.
package pclc_pkg;

  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam logic [7:0] LINK_CONTROL_OFS = 8'hb0;
  localparam logic [15:0] LINK_CONTROL_RST = 16'h0000;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int EXT_SYNCH_BIT = 7;
  localparam int COMMON_CLK_BIT = 6;
  localparam int RETRAIN_BIT = 5;
  localparam int DISABLE_BIT = 4;
  localparam int READ_COMPLETION_BOUNDARY_BIT = 3;
  localparam int ASPM_LSB = 0;
  localparam int ASPM_L0S_BIT = 0;
  localparam int ASPM_L1_BIT = 1;

  // Bits that software can write and read back.
  localparam logic [15:0] RW_MASK = 16'h00d3;
  // Read completion boundary of 64 bytes encodes as zero.
  localparam logic READ_COMPLETION_BOUNDARY_64 = 1'b0;

  // ----------------------------------------------------------------
  // Active state power management encodings
  // ----------------------------------------------------------------
  localparam logic [1:0] ASPM_OFF = 2'h0;
  localparam logic [1:0] ASPM_L0S = 2'h1;
  localparam logic [1:0] ASPM_L1 = 2'h2;
  localparam logic [1:0] ASPM_BOTH = 2'h3;

  // ----------------------------------------------------------------
  // Exit latency codes reported to the link capability logic
  // ----------------------------------------------------------------
  localparam logic [2:0] L0S_LAT_COMMON = 3'h2;
  localparam logic [2:0] L0S_LAT_ASYNC = 3'h4;
  localparam logic [2:0] L1_LAT_COMMON = 3'h2;
  localparam logic [2:0] L1_LAT_ASYNC = 3'h2;

endpackage : pclc_pkg

// ---- pclc_link_control.sv ----
// Purpose: Link control register of a root port, driving the training state machine.
// Assumes: Configuration port and state machine signals share mclk_in; no synchronisers needed.
// Notes: Reads answer one cycle after the read strobe; unmapped offsets read zero.
`timescale 1ns/1ps
module pclc_link_control #(
  parameter int ADDR_W = 8
) (
  input wire logic mclk_in,
  input wire logic rst_in,
  input wire logic cfg_wr_in,
  input wire logic cfg_rd_in,
  input wire logic [ADDR_W-1:0] cfg_addr_in,
  input wire logic [1:0] cfg_be_in,
  input wire logic [15:0] cfg_wdata_in,
  output logic [15:0] cfg_rdata_out,
  output logic cfg_rvalid_out,
  input wire logic ltssm_in_lx_in,
  input wire logic ltssm_cfg_rec_in,
  input wire logic ltssm_train_done_in,
  output logic ltssm_recovery_out,
  output logic ltssm_reset_retrain_out,
  output logic link_disable_out,
  output logic ext_synch_out,
  output logic common_clock_out,
  output logic aspm_l0s_en_out,
  output logic aspm_l1_en_out,
  output logic [2:0] l0s_exit_lat_out,
  output logic [2:0] l1_exit_lat_out,
  output logic link_training_out
);

  // ----------------------------------------------------------------
  // Parameter check
  // ----------------------------------------------------------------
  if (ADDR_W < 8) begin : g_bad_addr
    $error("ADDR_W must be at least 8 to reach the register offset.");
  end

  // ----------------------------------------------------------------
  // Decode
  // ----------------------------------------------------------------
  function automatic logic hit(input logic [ADDR_W-1:0] addr);
    hit = (addr == ADDR_W'(pclc_pkg::LINK_CONTROL_OFS));
  endfunction : hit

  logic wr_lo;
  logic retrain_wr;
  logic [15:0] ctl_ff;
  logic retrain_pend_ff;
  logic dis_prev_ff;
  logic cfg_rec_prev_ff;
  logic training_ff;
  logic recovery_ff;
  logic reset_retrain_ff;
  logic [15:0] rdata_ff;
  logic rvalid_ff;
  logic nxt_pend;
  logic nxt_training;
  logic train_exit;
  logic [15:0] read_value;

  assign wr_lo = cfg_wr_in && hit(cfg_addr_in) && cfg_be_in[0];
  assign retrain_wr = wr_lo && cfg_wdata_in[pclc_pkg::RETRAIN_BIT];

  // ----------------------------------------------------------------
  // Control register
  // ----------------------------------------------------------------
  always_ff @(posedge mclk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      ctl_ff <= pclc_pkg::LINK_CONTROL_RST;
    end
    else if (wr_lo)
    begin
      ctl_ff <= cfg_wdata_in & pclc_pkg::RW_MASK;
    end
  end

  // Only the stored bits appear; retrain, boundary and reserved read zero.
  always_comb
  begin
    read_value = ctl_ff & pclc_pkg::RW_MASK;
    read_value[pclc_pkg::READ_COMPLETION_BOUNDARY_BIT] = pclc_pkg::READ_COMPLETION_BOUNDARY_64;
  end

  always_ff @(posedge mclk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      rdata_ff <= 16'h0000;
      rvalid_ff <= 1'b0;
    end
    else
    begin
      rvalid_ff <= cfg_rd_in;
      rdata_ff <= (cfg_rd_in && hit(cfg_addr_in)) ? read_value : 16'h0000;
    end
  end

  // ----------------------------------------------------------------
  // Retraining
  // ----------------------------------------------------------------
  // A request waits until the state machine is in L0, L0s or L1; a new write wins over the clear.
  assign nxt_pend = retrain_wr || (retrain_pend_ff && !ltssm_in_lx_in);

  always_ff @(posedge mclk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      retrain_pend_ff <= 1'b0;
      recovery_ff <= 1'b0;
    end
    else
    begin
      retrain_pend_ff <= nxt_pend;
      recovery_ff <= retrain_pend_ff && ltssm_in_lx_in;
    end
  end

  always_ff @(posedge mclk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      dis_prev_ff <= 1'b0;
      reset_retrain_ff <= 1'b0;
    end
    else
    begin
      dis_prev_ff <= ctl_ff[pclc_pkg::DISABLE_BIT];
      reset_retrain_ff <= dis_prev_ff && !ctl_ff[pclc_pkg::DISABLE_BIT];
    end
  end

  // ----------------------------------------------------------------
  // Training status
  // ----------------------------------------------------------------
  assign train_exit = cfg_rec_prev_ff && !ltssm_cfg_rec_in && ltssm_train_done_in;
  assign nxt_training = retrain_wr || ltssm_cfg_rec_in || (training_ff && !train_exit);

  always_ff @(posedge mclk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      cfg_rec_prev_ff <= 1'b0;
      training_ff <= 1'b0;
    end
    else
    begin
      cfg_rec_prev_ff <= ltssm_cfg_rec_in;
      training_ff <= nxt_training;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign cfg_rdata_out = rdata_ff;
  assign cfg_rvalid_out = rvalid_ff;
  assign ltssm_recovery_out = recovery_ff;
  assign ltssm_reset_retrain_out = reset_retrain_ff;
  assign link_disable_out = ctl_ff[pclc_pkg::DISABLE_BIT];
  assign ext_synch_out = ctl_ff[pclc_pkg::EXT_SYNCH_BIT];
  assign common_clock_out = ctl_ff[pclc_pkg::COMMON_CLK_BIT];
  assign aspm_l0s_en_out = ctl_ff[pclc_pkg::ASPM_L0S_BIT];
  assign aspm_l1_en_out = ctl_ff[pclc_pkg::ASPM_L1_BIT];
  assign l0s_exit_lat_out = common_clock_out ? pclc_pkg::L0S_LAT_COMMON : pclc_pkg::L0S_LAT_ASYNC;
  assign l1_exit_lat_out = common_clock_out ? pclc_pkg::L1_LAT_COMMON : pclc_pkg::L1_LAT_ASYNC;
  assign link_training_out = training_ff;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  property p_ext_synch;
    @(posedge mclk_in) disable iff (rst_in)
    wr_lo |=> ext_synch_out == $past(cfg_wdata_in[7]);
  endproperty
  a_ext_synch: assert property (p_ext_synch) else $error("Extended synch bit not stored.");

  property p_common_clk;
    @(posedge mclk_in) disable iff (rst_in)
    wr_lo |=> common_clock_out == $past(cfg_wdata_in[6]);
  endproperty
  a_common_clk: assert property (p_common_clk) else $error("Common clock bit not stored.");

  property p_latency;
    @(posedge mclk_in) disable iff (rst_in)
    common_clock_out |-> l0s_exit_lat_out == 3'h2;
  endproperty
  a_latency: assert property (p_latency) else $error("L0s latency wrong with common clock.");

  property p_retrain;
    @(posedge mclk_in) disable iff (rst_in)
    retrain_wr ##1 ltssm_in_lx_in |=> ltssm_recovery_out;
  endproperty
  a_retrain: assert property (p_retrain) else $error("Retrain did not direct to Recovery.");

  property p_retrain_reads_zero;
    @(posedge mclk_in) disable iff (rst_in)
    cfg_rvalid_out |-> !cfg_rdata_out[5];
  endproperty
  a_retrain_reads_zero: assert property (p_retrain_reads_zero) else $error("Retrain bit read as one.");

  property p_auto_retrain;
    @(posedge mclk_in) disable iff (rst_in)
    $fell(link_disable_out) |=> ltssm_reset_retrain_out ##1 !ltssm_reset_retrain_out;
  endproperty
  a_auto_retrain: assert property (p_auto_retrain) else $error("No retrain pulse after disable release.");

  property p_disable_readback;
    @(posedge mclk_in) disable iff (rst_in)
    wr_lo ##1 (cfg_rd_in && hit(cfg_addr_in)) |=> cfg_rdata_out[4] == $past(cfg_wdata_in[4], 2);
  endproperty
  a_disable_readback: assert property (p_disable_readback) else $error("Link disable readback stale.");

  property p_reserved_zero;
    @(posedge mclk_in) disable iff (rst_in)
    cfg_rvalid_out |-> (cfg_rdata_out & 16'hff2c) == 16'h0000;
  endproperty
  a_reserved_zero: assert property (p_reserved_zero) else $error("Fixed or reserved bits read nonzero.");

  property p_aspm;
    @(posedge mclk_in) disable iff (rst_in)
    wr_lo && cfg_wdata_in[1:0] == 2'h3 |=> aspm_l0s_en_out && aspm_l1_en_out;
  endproperty
  a_aspm: assert property (p_aspm) else $error("Power management permission mismatch.");

  property p_training;
    @(posedge mclk_in) disable iff (rst_in)
    retrain_wr |=> link_training_out;
  endproperty
  a_training: assert property (p_training) else $error("Training status not raised.");

  c_retrain: cover property (@(posedge mclk_in) disable iff (rst_in) retrain_wr ##[1:20] ltssm_recovery_out);
  c_disable: cover property (@(posedge mclk_in) disable iff (rst_in) $fell(link_disable_out));
  c_train_end: cover property (@(posedge mclk_in) disable iff (rst_in) $fell(link_training_out));

endmodule : pclc_link_control

// ---- pclc_ltssm_model.sv ----
// Purpose: Behavioural training state machine facing the link control register.
// Assumes: Shares mclk_in; slow_in stretches each training pass.
// Notes: Training ends with done raised as the Configuration/Recovery level drops.
`timescale 1ns/1ps
module pclc_ltssm_model (
  input wire logic mclk_in,
  input wire logic rst_in,
  input wire logic recovery_in,
  input wire logic reset_retrain_in,
  input wire logic disable_in,
  input wire logic slow_in,
  output logic in_lx_out,
  output logic cfg_rec_out,
  output logic train_done_out
);
  logic [3:0] cnt_ff;
  logic rec_ff;
  logic done_ff;
  always_ff @(posedge mclk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      cnt_ff <= 4'h0;
      rec_ff <= 1'b0;
      done_ff <= 1'b0;
    end
    else if (recovery_in || reset_retrain_in)
    begin
      cnt_ff <= slow_in ? 4'hc : 4'h2;
      rec_ff <= 1'b1;
      done_ff <= 1'b0;
    end
    else if (cnt_ff != 4'h0)
      cnt_ff <= cnt_ff - 4'h1;
    else if (rec_ff)
    begin
      rec_ff <= 1'b0;
      done_ff <= 1'b1;
    end
  end
  assign cfg_rec_out = rec_ff;
  assign train_done_out = done_ff;
  assign in_lx_out = !rec_ff && !disable_in;
endmodule : pclc_ltssm_model

// ---- pclc_link_control_tb.sv ----
// Purpose: Self-checking bench for the link control register.
// Assumes: Inputs change on the falling edge; reads are scored from a queue.
// Notes: Random data comes from an LFSR seeded at a fixed value.
`timescale 1ns/1ps
module pclc_link_control_tb;
  logic mclk_in = 1'b0;
  logic rst_in = 1'b1;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic [7:0] addr = 8'h00;
  logic [1:0] be = 2'h0;
  logic [15:0] wdata = 16'h0000;
  logic slow = 1'b0;
  logic [15:0] rdata;
  logic rvalid, lx, crec, done, recov, rret, dis, esync, cclk, l0s, l1, trn;
  logic [2:0] lat0, lat1;
  logic [15:0] exp_q[$];
  logic [31:0] seed = 32'h7cb31c15;
  logic [15:0] d;
  int miscompares = 0;
  int n_checks = 0;
  int cyc = 0;
  int n;
  always #20 mclk_in = ~mclk_in;
  pclc_link_control pclc_link_control_i (.mclk_in(mclk_in), .rst_in(rst_in), .cfg_wr_in(wr), .cfg_rd_in(rd),
    .cfg_addr_in(addr), .cfg_be_in(be), .cfg_wdata_in(wdata), .cfg_rdata_out(rdata), .cfg_rvalid_out(rvalid),
    .ltssm_in_lx_in(lx), .ltssm_cfg_rec_in(crec), .ltssm_train_done_in(done), .ltssm_recovery_out(recov),
    .ltssm_reset_retrain_out(rret), .link_disable_out(dis), .ext_synch_out(esync), .common_clock_out(cclk),
    .aspm_l0s_en_out(l0s), .aspm_l1_en_out(l1), .l0s_exit_lat_out(lat0), .l1_exit_lat_out(lat1),
    .link_training_out(trn));
  pclc_ltssm_model pclc_ltssm_model_i (.mclk_in(mclk_in), .rst_in(rst_in), .recovery_in(recov),
    .reset_retrain_in(rret), .disable_in(dis), .slow_in(slow), .in_lx_out(lx), .cfg_rec_out(crec),
    .train_done_out(done));
  // ----------------------------------------------------------------
  // Bus tasks and scoring
  // ----------------------------------------------------------------
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr
  task automatic check(input logic [15:0] seen, input logic [15:0] want);
    n_checks++;
    if (seen !== want)
    begin
      miscompares++;
      $display("unexpected at %0t: got %h want %h", $time, seen, want);
    end
  endtask : check
  task automatic wr_reg(input logic [7:0] a, input logic [1:0] b, input logic [15:0] v);
    @(negedge mclk_in);
    wr = 1'b1;
    addr = a;
    be = b;
    wdata = v;
    @(negedge mclk_in);
    wr = 1'b0;
  endtask : wr_reg
  task automatic rd_reg(input logic [7:0] a, input logic [15:0] want);
    @(negedge mclk_in);
    rd = 1'b1;
    addr = a;
    exp_q.push_back(want);
    @(negedge mclk_in);
    rd = 1'b0;
  endtask : rd_reg
  // A write followed at once by a read, so the readback sees the value just written.
  task automatic wr_rd(input logic [15:0] v, input logic [15:0] want);
    @(negedge mclk_in);
    wr = 1'b1;
    addr = 8'hb0;
    be = 2'h1;
    wdata = v;
    @(negedge mclk_in);
    wr = 1'b0;
    rd = 1'b1;
    exp_q.push_back(want);
    @(negedge mclk_in);
    rd = 1'b0;
  endtask : wr_rd
  task automatic complete_run;
    if (miscompares == 0 && n_checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : complete_run
  always @(negedge mclk_in)
    if (rvalid === 1'b1)
      check(rdata, (exp_q.size() > 0) ? exp_q.pop_front() : 16'hdead);
  always @(posedge mclk_in)
  begin
    cyc++;
    if (cyc == 5000)
    begin
      miscompares++;
      complete_run();
    end
  end
  initial
  begin
    repeat (12) @(negedge mclk_in);
    rst_in = 1'b0;
    rd_reg(8'hb0, 16'h0000);
    for (int i = 0; i < 16; i++)
    begin
      seed = lfsr(seed);
      d = {seed[15:2], i[1:0]};
      wr_reg(8'hb0, 2'h1, d);
      check({5'h0, esync, cclk, dis, l1, l0s, lat0, lat1}, {5'h0, d[7], d[6], d[4], d[1], d[0],
        d[6] ? pclc_pkg::L0S_LAT_COMMON : pclc_pkg::L0S_LAT_ASYNC,
        d[6] ? pclc_pkg::L1_LAT_COMMON : pclc_pkg::L1_LAT_ASYNC});
      rd_reg(8'hb0, d & 16'h00d3);
      wr_reg(8'hb0, 2'h2, ~d);
      rd_reg(8'hb4, 16'h0000);
      rd_reg(8'hb0, d & 16'h00d3);
      wr_rd(~d, ~d & 16'h00d3);
    end
    wr_reg(8'hb0, 2'h1, 16'h0000);
    repeat (30) @(negedge mclk_in);
    for (int s = 0; s < 2; s++)
    begin
      slow = s[0];
      wr_reg(8'hb0, 2'h1, 16'h0020);
      check({15'h0, trn}, 16'h0001);
      n = 0;
      while (recov !== 1'b1 && n < 4)
      begin
        @(negedge mclk_in);
        n++;
      end
      check({15'h0, recov}, 16'h0001);
      rd_reg(8'hb0, 16'h0000);
      n = 0;
      while (trn !== 1'b0 && n < 40)
      begin
        @(negedge mclk_in);
        n++;
      end
      check({15'h0, trn}, 16'h0000);
    end
    wr_reg(8'hb0, 2'h1, 16'h0010);
    check({14'h0, dis, lx}, 16'h0002);
    rd_reg(8'hb0, 16'h0010);
    wr_reg(8'hb0, 2'h1, 16'h0000);
    @(negedge mclk_in);
    check({15'h0, rret}, 16'h0001);
    repeat (30) @(negedge mclk_in);
    check(16'(exp_q.size()), 16'h0000);
    complete_run();
  end
endmodule : pclc_link_control_tb
